/* core/smc_consts.svh */
// Constants of the sleep mode controller
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SMC_IDX_SLEEP_CTRL 8'h87
`define SMC_ADDR_SLEEP_CTRL 12'h21C
`define SMC_ADDR_WDOG_CTRL 12'h220
`define SMC_ADDR_WAKE_EN 12'h224
`define SMC_ADDR_STATUS 12'h228
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMC_BIT_HALT 0
`define SMC_BIT_DEEP 1
`define SMC_BIT_KEEPALIVE 4
`define SMC_BIT_EXT0_EN 0
`define SMC_BIT_EXT1_EN 1
`define SMC_BIT_WKT_EN 2
`define SMC_BIT_BOD_EN 3
`define SMC_BIT_GLOBAL 7
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define SMC_RST_SLEEP_CTRL 8'h00
`define SMC_RST_WDOG_CTRL 8'h00
`define SMC_RST_WAKE_EN 8'h00
`define SMC_MASK_SLEEP_CTRL 8'h9F
`define SMC_MASK_WDOG_CTRL 8'h10
`define SMC_MASK_WAKE_EN 8'h8F
`endif

/* core/smc_pkg.sv */
// Types of the sleep mode controller
package smc_pkg;
   // ----------------------------------------
   // Power state
   // ----------------------------------------
   typedef enum logic [2:0] {
      SMC_RUN = 3'b001,
      SMC_LIGHT = 3'b010,
      SMC_DEEP = 3'b100
   } smc_state_t;

   // ----------------------------------------
   // Whole module state
   // ----------------------------------------
   typedef struct packed {
      smc_state_t state;
      logic [7:0] sleep_ctrl;
      logic [7:0] wdog_ctrl;
      logic [7:0] wake_en;
      logic entry_pending;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic osc_run;
      logic flash_en;
      logic fetch_hold;
      logic port_hold;
      logic wdog_run;
      logic wdog_clear;
      logic irq_wake;
      logic core_restart;
   } smc_regs_t;
endpackage : smc_pkg

/* core/smc_top.sv */
// Sleep mode controller with APB register access
// Notes on behaviour
// R1: Halt request bit gates CPU clock, freezes PC, peripheral clocks keep running.
// R2: Deep request bit stops CPU and peripheral clocks and suspends PC.
// R3: Both bits written together give deep sleep only, no halt afterwards.
// R4: Interrupt wake clears the sleep request bit by hardware.
// R5: Core services waking interrupt, then resumes after the sleep instruction.
// R6: Sleep is entered only after the requesting instruction retires.
// R7: Halt state keeps all CPU registers and fetches no code.
// R8: Halt state holds port pins at their levels on entry.
// R9: Any enabled interrupt ends halt state.
// R10: Any reset except software reset ends halt state.
// R11: Watchdog counts in halt only with keepalive bit set; software sets it.
// R12: Watchdog counter cleared on entry to and wake from either sleep.
// R13: Deep sleep stops the system oscillator and the flash.
// R14: Deep sleep keeps RAM and ports driving their latched values.
// R15: Every non-software reset ends deep sleep, brown-out reset included.
// R16: Pin or power-on reset ends deep sleep with a full core restart.
// R17: Enabled external interrupt pin with global gate restarts the clock.
// R18: Wake timer and brown-out interrupts also wake from deep sleep.
// R19: Any reset leaves both sleep request bits cleared.
`include "smc_consts.svh"

module smc_top
   import smc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core side
   input wire logic instr_retire,
   input wire logic irq_pending,
   input wire logic reset_event,
   input wire logic soft_reset,
   // Wake sources
   input wire logic [1:0] ext_int,
   input wire logic wake_timer_irq,
   input wire logic brownout_irq,
   // Clock and power controls
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic flash_en,
   output logic fetch_hold,
   output logic port_hold,
   // Watchdog and interrupt side
   output logic wdog_run,
   output logic wdog_clear,
   output logic irq_wake,
   output logic core_restart,
   output logic [2:0] power_state
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   smc_regs_t s_q;
   smc_regs_t s_d;
   logic wr_en;
   logic rd_setup;
   logic hit;
   logic deep_wake;
   logic any_reset;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign wr_en = psel & penable & pwrite & s_q.pready;
   assign rd_setup = psel & ~penable;
   assign hit = (paddr == `SMC_ADDR_SLEEP_CTRL) || (paddr == `SMC_ADDR_WDOG_CTRL) ||
                (paddr == `SMC_ADDR_WAKE_EN) || (paddr == `SMC_ADDR_STATUS);
   assign any_reset = reset_event | soft_reset;

   // Interrupt sources able to wake deep sleep
   assign deep_wake = s_q.wake_en[`SMC_BIT_GLOBAL] & (
                      (ext_int[0] & s_q.wake_en[`SMC_BIT_EXT0_EN]) |      // [R17]
                      (ext_int[1] & s_q.wake_en[`SMC_BIT_EXT1_EN]) |      // [R17]
                      (wake_timer_irq & s_q.wake_en[`SMC_BIT_WKT_EN]) |   // [R18]
                      (brownout_irq & s_q.wake_en[`SMC_BIT_BOD_EN]));     // [R18]

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.wdog_clear = 1'b0;
      s_d.irq_wake = 1'b0;
      s_d.core_restart = 1'b0;

      // APB answer one cycle after setup
      s_d.pready = rd_setup;
      s_d.pslverr = rd_setup & ~hit;
      if (rd_setup) begin
         case (paddr)
            `SMC_ADDR_SLEEP_CTRL: s_d.prdata = {24'h000000, s_q.sleep_ctrl};
            `SMC_ADDR_WDOG_CTRL: s_d.prdata = {24'h000000, s_q.wdog_ctrl};
            `SMC_ADDR_WAKE_EN: s_d.prdata = {24'h000000, s_q.wake_en};
            `SMC_ADDR_STATUS: s_d.prdata = {28'h0000000, s_q.entry_pending, s_q.state};
            default: s_d.prdata = 32'h00000000;
         endcase
      end

      // Register writes
      if (wr_en) begin
         case (paddr)
            `SMC_ADDR_SLEEP_CTRL: begin
               s_d.sleep_ctrl = pwdata[7:0] & `SMC_MASK_SLEEP_CTRL;
               if (pwdata[`SMC_BIT_HALT] | pwdata[`SMC_BIT_DEEP]) begin
                  s_d.entry_pending = 1'b1;
               end
            end
            `SMC_ADDR_WDOG_CTRL: s_d.wdog_ctrl = pwdata[7:0] & `SMC_MASK_WDOG_CTRL;   // [R11]
            `SMC_ADDR_WAKE_EN: s_d.wake_en = pwdata[7:0] & `SMC_MASK_WAKE_EN;
            default: begin
            end
         endcase
      end

      // Power state sequencing
      case (s_q.state)
         SMC_RUN: begin
            if (s_q.entry_pending & instr_retire) begin   // [R6]
               s_d.entry_pending = 1'b0;
               s_d.wdog_clear = 1'b1;   // [R12]
               if (s_q.sleep_ctrl[`SMC_BIT_DEEP]) begin
                  s_d.state = SMC_DEEP;   // [R2] [R3]
               end else if (s_q.sleep_ctrl[`SMC_BIT_HALT]) begin
                  s_d.state = SMC_LIGHT;   // [R1]
               end
            end
         end
         SMC_LIGHT: begin
            if (reset_event) begin
               s_d.state = SMC_RUN;   // [R10]
               s_d.wdog_clear = 1'b1;   // [R12]
            end else if (irq_pending) begin
               s_d.state = SMC_RUN;   // [R9]
               s_d.sleep_ctrl[`SMC_BIT_HALT] = 1'b0;   // [R4]
               s_d.wdog_clear = 1'b1;   // [R12]
               s_d.irq_wake = 1'b1;   // [R5]
            end
         end
         SMC_DEEP: begin
            if (reset_event) begin
               s_d.state = SMC_RUN;   // [R15]
               s_d.wdog_clear = 1'b1;   // [R12]
               s_d.core_restart = 1'b1;   // [R16]
            end else if (deep_wake) begin
               s_d.state = SMC_RUN;
               s_d.sleep_ctrl[`SMC_BIT_DEEP] = 1'b0;   // [R4]
               s_d.sleep_ctrl[`SMC_BIT_HALT] = 1'b0;   // [R3]
               s_d.wdog_clear = 1'b1;   // [R12]
               s_d.irq_wake = 1'b1;   // [R5]
            end
         end
         default: s_d.state = SMC_RUN;
      endcase

      // Resets other than power-on clear the requests
      if (any_reset) begin
         s_d.sleep_ctrl[`SMC_BIT_HALT] = 1'b0;   // [R19]
         s_d.sleep_ctrl[`SMC_BIT_DEEP] = 1'b0;   // [R19]
         s_d.entry_pending = 1'b0;
      end
      if (soft_reset & (s_q.state == SMC_RUN)) begin
         s_d.state = SMC_RUN;
      end

      // Clock and hold controls from the next state
      case (s_d.state)
         SMC_LIGHT: begin
            s_d.cpu_clk_en = 1'b0;   // [R1]
            s_d.periph_clk_en = 1'b1;   // [R1] [R9]
            s_d.osc_run = 1'b1;
            s_d.flash_en = 1'b1;
            s_d.fetch_hold = 1'b1;   // [R7]
            s_d.port_hold = 1'b1;   // [R8]
            s_d.wdog_run = s_d.wdog_ctrl[`SMC_BIT_KEEPALIVE];   // [R11]
         end
         SMC_DEEP: begin
            s_d.cpu_clk_en = 1'b0;   // [R2]
            s_d.periph_clk_en = 1'b0;   // [R2]
            s_d.osc_run = 1'b0;   // [R13]
            s_d.flash_en = 1'b0;   // [R13]
            s_d.fetch_hold = 1'b1;   // [R2]
            s_d.port_hold = 1'b1;   // [R14]
            s_d.wdog_run = 1'b0;
         end
         default: begin
            s_d.cpu_clk_en = 1'b1;
            s_d.periph_clk_en = 1'b1;
            s_d.osc_run = 1'b1;
            s_d.flash_en = 1'b1;
            s_d.fetch_hold = 1'b0;
            s_d.port_hold = 1'b0;
            s_d.wdog_run = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{state: SMC_RUN, sleep_ctrl: `SMC_RST_SLEEP_CTRL,   // [R19] [R16]
                  wdog_ctrl: `SMC_RST_WDOG_CTRL, wake_en: `SMC_RST_WAKE_EN,
                  entry_pending: 1'b0, prdata: 32'h00000000, pready: 1'b0,
                  pslverr: 1'b0, cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                  osc_run: 1'b1, flash_en: 1'b1, fetch_hold: 1'b0,
                  port_hold: 1'b0, wdog_run: 1'b1, wdog_clear: 1'b0,
                  irq_wake: 1'b0, core_restart: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign cpu_clk_en = s_q.cpu_clk_en;
   assign periph_clk_en = s_q.periph_clk_en;
   assign osc_run = s_q.osc_run;
   assign flash_en = s_q.flash_en;
   assign fetch_hold = s_q.fetch_hold;
   assign port_hold = s_q.port_hold;
   assign wdog_run = s_q.wdog_run;
   assign wdog_clear = s_q.wdog_clear;
   assign irq_wake = s_q.irq_wake;
   assign core_restart = s_q.core_restart;
   assign power_state = s_q.state;

endmodule : smc_top

/* tb/smc_monitor.sv */
// Checker of the sleep mode controller ports
module smc_monitor (
   // Clock, reset and bus
   input wire logic ref_clk, nrst, psel, penable, pready,
   // Core side inputs
   input wire logic instr_retire, irq_pending, reset_event,
   // Clock, hold and pulse outputs
   input wire logic cpu_clk_en, periph_clk_en, osc_run, flash_en, fetch_hold, port_hold,
   input wire logic wdog_clear, irq_wake, core_restart,
   input wire logic [2:0] power_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ---
   // Assertions
   // ---
   AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready pulse wrong");
   AST_LIGHT_CLK: assert property (power_state == 3'h2 |-> !cpu_clk_en && periph_clk_en && fetch_hold)
      else $error("light clocks wrong");
   AST_DEEP_CLK: assert property (power_state == 3'h4 |-> !(cpu_clk_en || periph_clk_en || osc_run || flash_en))
      else $error("deep clocks wrong");
   AST_PORT_HOLD: assert property (power_state != 3'h1 |-> port_hold)
      else $error("ports not held");
   AST_WDOG_CLR: assert property ($changed(power_state) |-> wdog_clear)
      else $error("watchdog not cleared");
   AST_LIGHT_WAKE: assert property (power_state == 3'h2 && irq_pending |=> power_state == 3'h1)
      else $error("light not woken");
   AST_WAKE_PULSE: assert property (irq_wake |-> $past(power_state) != 3'h1 && power_state == 3'h1)
      else $error("wake pulse wrong");
   AST_RESTART: assert property (power_state == 3'h4 && reset_event |=> core_restart && power_state == 3'h1)
      else $error("no restart");
   AST_ENTRY: assert property (power_state == 3'h1 && !instr_retire |=> power_state == 3'h1)
      else $error("early sleep");
   cover property (power_state == 3'h2 && irq_pending);
   cover property (power_state == 3'h4 && reset_event);
   cover property (irq_wake && $past(power_state) == 3'h4);
endmodule : smc_monitor

bind smc_top smc_monitor u_mon (.*);

/* tb/smc_cpu_model.sv */
// Core, interrupt controller and watchdog model
module smc_cpu_model (
   // Clock and reset
   input wire logic ref_clk, nrst,
   // Bus observation
   input wire logic psel, penable, pwrite, pready,
   // Interrupt and watchdog control
   input wire logic irq_req, wdog_run, wdog_clear,
   // Core outputs
   output logic instr_retire, irq_pending,
   output logic [7:0] wd_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   assign irq_pending = irq_req;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         instr_retire <= 1'b0;
         wd_cnt <= 8'h00;
      end else begin
         instr_retire <= psel & penable & pready & pwrite;
         wd_cnt <= wdog_clear ? 8'h00 : wd_cnt + {7'h00, wdog_run};
      end
   end
endmodule : smc_cpu_model

/* tb/tb.sv */
// Testbench of the sleep mode controller
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0;
   logic soft_reset = 1'b0, reset_event = 1'b0, wake_timer_irq = 1'b0, brownout_irq = 1'b0;
   logic [1:0] ext_int = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, instr_retire, irq_pending, cpu_clk_en, periph_clk_en, osc_run;
   logic flash_en, fetch_hold, port_hold, wdog_run, wdog_clear, irq_wake, core_restart;
   logic [2:0] power_state;
   logic [7:0] wd_cnt;
   logic [7:0] en_tab [4] = '{8'h81, 8'h84, 8'h88, 8'h01};
   int n_fail = 0, tests_run = 0, cyc = 0;

   smc_top dut (.*);
   smc_cpu_model u_cpu (.*);

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end
   // ---
   // Tasks
   // ---
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
      xfer(1'b0, a, 32'h0);
      chk("prdata", e, rdat);
      chk("pslverr", err, rerr);
   endtask : rd

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic close_out;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   // ---
   // Sequence
   // ---
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(12'h21C, 32'h0, 1'b0);
      chk("state", 3'h1, power_state);
      rd(12'h300, 32'h0, 1'b1);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         wr(12'h220, k ? 8'h10 : 8'h00);
         wr(12'h21C, 8'h01);
         step(2);
         chk("state", 3'h2, power_state);
         chk("clocks", 2'b01, {cpu_clk_en, periph_clk_en});
         chk("holds", 2'b11, {fetch_hold, port_hold});
         chk("osc_flash", 2'b11, {osc_run, flash_en});
         chk("wdog_run", k, wdog_run);
         step(3);
         chk("wd_cnt", 3 * k, wd_cnt);
         @(posedge ref_clk);
         if (k) reset_event <= 1'b1;
         else irq_req <= 1'b1;
         step(1);
         chk("state", 3'h1, power_state);
         chk("pulses", {k == 0, 1'b1, 1'b0}, {irq_wake, wdog_clear, core_restart});
         @(posedge ref_clk);
         reset_event <= 1'b0;
         irq_req <= 1'b0;
         rd(12'h21C, 32'h0, 1'b0);
      end
      rd(12'h220, 32'h10, 1'b0);
      rd(12'h228, 32'h1, 1'b0);
      $display("test light done");
      for (int i = 0; i < 4; i++) begin
         wr(12'h224, en_tab[i]);
         wr(12'h21C, 8'h03);
         step(2);
         chk("state", 3'h4, power_state);
         chk("clocks", 4'h0, {cpu_clk_en, periph_clk_en, osc_run, flash_en});
         chk("hold", 1'b1, port_hold);
         @(posedge ref_clk);
         soft_reset <= 1'b1;
         ext_int <= (i == 3) ? 2'h1 : 2'h2;
         step(1);
         chk("state", 3'h4, power_state);
         @(posedge ref_clk);
         soft_reset <= 1'b0;
         ext_int <= {1'b0, i == 0};
         wake_timer_irq <= i == 1;
         brownout_irq <= i == 2;
         reset_event <= i == 3;
         step(1);
         chk("state", 3'h1, power_state);
         chk("pulses", {i < 3, 1'b1, i == 3}, {irq_wake, wdog_clear, core_restart});
         @(posedge ref_clk);
         {ext_int, wake_timer_irq, brownout_irq, reset_event} <= 5'h00;
         rd(12'h21C, 32'h0, 1'b0);
         chk("state", 3'h1, power_state);
      end
      $display("test deep done");
      close_out();
   end
endmodule : tb
